// file: mfc_pkg.sv
// mfc_pkg: constants and types of the mac frame config / phy management block
// assumes a 20 MHz system clock and a word-addressed avalon-mm register port
package mfc_pkg;

   // timing
   localparam int CLK_PERIOD_NS   = 50;
   localparam int MGMT_XACT_NS    = 10240;
   localparam int MGMT_FRAME_BITS = 64;
   localparam int MGMT_BIT_NS     = MGMT_XACT_NS / MGMT_FRAME_BITS;
   localparam int MGMT_BIT_CYC    =
      (MGMT_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int START_DELAY_CYC = 2;
   // bits driven by us in a read frame: preamble, start, op, addresses
   localparam int MGMT_RD_DRIVE   = 46;
   localparam int CRC_BYTES       = 4;
   localparam int HEADER_BYTES    = 4;

   // register word indices
   localparam logic [3:0] REG_FRAME_CFG = 4'h0;
   localparam logic [3:0] REG_DEFER_CTL = 4'h1;
   localparam logic [3:0] REG_MGMT_CMD  = 4'h2;
   localparam logic [3:0] REG_MGMT_STAT = 4'h3;
   localparam logic [3:0] REG_PHY_SEL   = 4'h4;
   localparam logic [3:0] REG_RD_LOW    = 4'h5;
   localparam logic [3:0] REG_RD_HIGH   = 4'h6;
   localparam logic [3:0] REG_WR_LOW    = 4'h7;
   localparam logic [3:0] REG_WR_HIGH   = 4'h8;
   localparam logic [3:0] REG_MAX_LEN   = 4'h9;

   // field positions
   localparam int FC_PAD_LSB   = 5;
   localparam int FC_CRC_EN    = 4;
   localparam int FC_HEADER    = 3;
   localparam int FC_OVERSIZE  = 2;
   localparam int FC_LEN_CHECK = 1;
   localparam int FC_FULL_DPX  = 0;
   localparam int DC_DEFER     = 6;
   localparam logic [7:0] DC_RSVD_MASK = 8'h30;
   localparam int CMD_SCAN     = 1;
   localparam int CMD_READ     = 0;
   localparam int ST_PENDING   = 2;
   localparam int ST_SCAN      = 1;
   localparam int ST_BUSY      = 0;
   localparam logic [15:0] MAX_FRAME_RST = 16'h05ee;

   // management frame codes
   localparam logic [1:0] MF_START    = 2'h1;
   localparam logic [1:0] MF_OP_READ  = 2'h2;
   localparam logic [1:0] MF_OP_WRITE = 2'h1;
   localparam logic [1:0] MF_TA_WRITE = 2'h2;

   typedef struct packed {
      logic [2:0]  pad_cfg;
      logic        crc_append;
      logic        crc_check_tail;
      logic        crc_skip_header;
      logic        truncate_en;
      logic [15:0] max_len;
      logic        length_check;
      logic        full_duplex;
      logic        defer_unbounded;
   } mfc_frame_ctrl_type;

   typedef struct packed {
      logic        is_read;
      logic [4:0]  reg_addr;
      logic [15:0] wdata;
   } mfc_mgmt_req_type;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_DELAY = 3'b010,
      ST_RUN   = 3'b100
   } mfc_state_type;

endpackage

// file: mfc_mgmt_engine.sv
// mfc_mgmt_engine: serial management frame engine toward the phy
// assumes start only while idle; pins are synchronous to clk_sys
`timescale 1ns/1ps
module mfc_mgmt_engine #(
   parameter logic [4:0] PHY_ADDR = 5'h01,
   parameter int         BIT_CYC  = mfc_pkg::MGMT_BIT_CYC
) (
   // clock and reset
   input  wire logic                      clk_sys,
   input  wire logic                      rst_n,
   // request and answer
   input  wire logic                      start,
   input  wire mfc_pkg::mfc_mgmt_req_type req,
   output      logic                      done,
   output      logic [15:0]               rdata,
   // management pins
   output      logic                      mdc,
   output      logic                      mdio_o,
   output      logic                      mdio_oe,
   input  wire logic                      mdio_i
);
   import mfc_pkg::*;

   if (BIT_CYC < 2 || BIT_CYC > 7) begin : g_chk
      $error("BIT_CYC out of range");
   end

   logic [63:0] shift_q;
   logic [6:0]  bits_q;
   logic [2:0]  ph_q;
   logic        active_q;
   logic        rd_q;
   logic [15:0] cap_q;

   localparam logic [2:0] PH_LAST = 3'(BIT_CYC - 1);
   localparam logic [2:0] PH_RISE = 3'(BIT_CYC / 2);
   localparam logic [6:0] RD_LAST = 7'(MGMT_FRAME_BITS - MGMT_RD_DRIVE);

   wire ph_zero = active_q && ph_q == 3'h0;
   wire ph_rise = active_q && ph_q == PH_RISE;
   wire ph_end  = active_q && ph_q == PH_LAST;
   wire [1:0] op_code = req.is_read ? MF_OP_READ : MF_OP_WRITE;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         shift_q  <= 64'h0;
         bits_q   <= 7'h0;
         ph_q     <= 3'h0;
         active_q <= 1'b0;
         rd_q     <= 1'b0;
         cap_q    <= 16'h0;
         done     <= 1'b0;
         rdata    <= 16'h0;
         mdc      <= 1'b0;
         mdio_o   <= 1'b0;
         mdio_oe  <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !active_q) begin
            // clause 22 frame, preamble of ones first RULE26
            shift_q  <= {32'hffffffff, MF_START, op_code, PHY_ADDR,
                         req.reg_addr, MF_TA_WRITE, req.wdata};
            bits_q   <= 7'(MGMT_FRAME_BITS);
            ph_q     <= 3'h0;
            active_q <= 1'b1;
            rd_q     <= req.is_read;
         end else if (active_q) begin
            ph_q <= ph_end ? 3'h0 : ph_q + 3'h1;
         end
         if (ph_zero) begin
            mdc     <= 1'b0;
            mdio_o  <= shift_q[63];
            // read frames release the line from turnaround onward
            mdio_oe <= !rd_q || bits_q > RD_LAST;
         end
         if (ph_rise) begin
            mdc     <= 1'b1;
            cap_q   <= {cap_q[14:0], mdio_i};
            shift_q <= {shift_q[62:0], 1'b0};
            bits_q  <= bits_q - 7'h1;
         end
         if (ph_end && bits_q == 7'h0) begin
            active_q <= 1'b0;
            done     <= 1'b1;
            rdata    <= cap_q;
            mdio_oe  <= 1'b0;
            // park mdc low between frames
            mdc      <= 1'b0;
         end
      end
   end

   // helper: cycles since the frame began
   logic [9:0] len_q;
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !active_q)
         len_q <= 10'h0;
      else
         len_q <= len_q + 10'h1;
   end

   chk_frame_length: assert property (@(posedge clk_sys) // RULE21
      disable iff (!rst_n)
      done |-> $past(len_q) == 10'(MGMT_FRAME_BITS * BIT_CYC - 1))
      else $error("management frame length wrong");

   chk_read_release: assert property (@(posedge clk_sys) // RULE26
      disable iff (!rst_n)
      (active_q && rd_q && bits_q < RD_LAST && ph_q == PH_RISE) |-> !mdio_oe)
      else $error("read frame drives data phase");

endmodule // mfc_mgmt_engine

// file: mfc_mac_cfg_mgmt.sv
// mfc_mac_cfg_mgmt: mac frame options and phy management registers
// assumes an avalon-mm master and a phy on the management pins
//
// Summary of operation
// RULE1: crc append set appends valid crc always
// RULE2: software sets crc append when pad needs crc
// RULE3: append clear checks last four bytes instead
// RULE4: header enable excludes first four bytes from crc
// RULE5: oversize clear truncates beyond max frame length
// RULE6: length check compares length field, reports mismatch
// RULE7: duplex bit selects mode; software matches phy
// RULE8: defer set waits forever, else aborts
// RULE9: software keeps reserved deferral bits zero
// RULE10: repeat poll rereads selected phy register continually
// RULE11: single read reads selected register exactly once
// RULE12: pending set until read data updated
// RULE13: poll active status shows repeat poll running
// RULE14: busy rises two cycles after a start
// RULE15: phy registers sixteen bits, five bit address
// RULE16: unimplemented phy addresses never written
// RULE17: software writes reserved phy bits as specified
// RULE18: phy reached only via management after ready
// RULE19: latched link bit stays low after drop
// RULE20: second phy status reports link and activity; the phy model reports link only
// RULE21: upper write byte starts write; busy clears after
// RULE22: software waits busy, clears read, then reads
// RULE23: poll stop clears busy after last read
// RULE24: separate select, read and write data buffers
// RULE25: status writes ignored; unused bits read zero
// RULE26: phy frames use clause 22 format
`timescale 1ns/1ps
module mfc_mac_cfg_mgmt #(
   parameter logic [4:0] PHY_ADDR = 5'h01
) (
   // clock and reset
   input  wire logic                        clk_sys,
   input  wire logic                        rst_n,
   // avalon-mm slave
   input  wire logic [3:0]                  avs_address,
   input  wire logic                        avs_read,
   input  wire logic                        avs_write,
   input  wire logic [31:0]                 avs_writedata,
   input  wire logic [3:0]                  avs_byteenable,
   output      logic [31:0]                 avs_readdata,
   output      logic                        avs_waitrequest,
   // frame controls toward the mac datapath
   output      mfc_pkg::mfc_frame_ctrl_type frame_ctrl,
   // management pins
   output      logic                        mdc,
   output      logic                        mdio_o,
   output      logic                        mdio_oe,
   input  wire logic                        mdio_i
);
   import mfc_pkg::*;

   // bus access strobes
   wire       req_any = avs_read || avs_write;
   wire       acc     = req_any && !avs_waitrequest;
   wire       wr_lo   = avs_write && acc && avs_byteenable[0];
   wire       wr_b1   = avs_write && acc && avs_byteenable[1];
   wire [7:0] wd      = avs_writedata[7:0];

   function automatic logic hit(input logic [3:0] idx);
      return avs_address == idx;
   endfunction

   wire wr_frame = wr_lo && hit(REG_FRAME_CFG);
   wire wr_defer = wr_lo && hit(REG_DEFER_CTL);
   wire wr_cmd   = wr_lo && hit(REG_MGMT_CMD);
   wire wr_sel   = wr_lo && hit(REG_PHY_SEL);
   wire wr_wrl   = wr_lo && hit(REG_WR_LOW);
   wire wr_wrh   = wr_lo && hit(REG_WR_HIGH);
   wire wr_len0  = wr_lo && hit(REG_MAX_LEN);
   wire wr_len1  = wr_b1 && hit(REG_MAX_LEN);

   // management registers
   logic [4:0]    phy_reg_select_q;
   logic [7:0]    phy_read_data_low_q;
   logic [7:0]    phy_read_data_high_q;
   logic [7:0]    phy_write_data_low_q;
   logic [7:0]    phy_write_data_high_q;
   logic          cmd_scan_q;
   logic          cmd_read_q;
   logic          busy_q;
   logic          scan_st_q;
   logic          pend_q;
   logic [1:0]    defer_rsvd_q;
   mfc_state_type state_q;
   logic [1:0]    dly_q;
   logic          op_read_q;
   logic          op_scan_q;
   logic          eng_start_q;
   logic          eng_done;
   logic [15:0]   eng_rdata;

   // read and poll starts only act on a 0 to 1 command edge
   wire start_read = wr_cmd && wd[CMD_READ] && !cmd_read_q;
   wire start_scan = wr_cmd && wd[CMD_SCAN] && !cmd_scan_q;
   wire start_any  = start_read || start_scan || wr_wrh;
   wire idle       = state_q == ST_IDLE;

   // register read selection
   logic [15:0] rd_mux;
   always_comb begin
      rd_mux = 16'h0;
      if (hit(REG_FRAME_CFG))
         rd_mux = {8'h0, frame_ctrl.pad_cfg, frame_ctrl.crc_append,
                   frame_ctrl.crc_skip_header, !frame_ctrl.truncate_en,
                   frame_ctrl.length_check, frame_ctrl.full_duplex};
      else if (hit(REG_DEFER_CTL))
         rd_mux = {9'h0, frame_ctrl.defer_unbounded, defer_rsvd_q, 4'h0};
      else if (hit(REG_MGMT_CMD))
         rd_mux = {14'h0, cmd_scan_q, cmd_read_q};
      else if (hit(REG_MGMT_STAT))
         rd_mux = {13'h0, pend_q, scan_st_q, busy_q}; // RULE25
      else if (hit(REG_PHY_SEL))
         rd_mux = {11'h0, phy_reg_select_q};
      else if (hit(REG_RD_LOW))
         rd_mux = {8'h0, phy_read_data_low_q};
      else if (hit(REG_RD_HIGH))
         rd_mux = {8'h0, phy_read_data_high_q};
      else if (hit(REG_WR_LOW))
         rd_mux = {8'h0, phy_write_data_low_q};
      else if (hit(REG_WR_HIGH))
         rd_mux = {8'h0, phy_write_data_high_q};
      else if (hit(REG_MAX_LEN))
         rd_mux = frame_ctrl.max_len;
   end

   // one wait cycle, then the access completes
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0;
      end else if (acc) begin
         avs_waitrequest <= 1'b1;
      end else if (req_any) begin
         avs_waitrequest <= 1'b0;
         avs_readdata    <= {16'h0, rd_mux};
      end
   end

   // frame option registers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         frame_ctrl                 <= '0;
         frame_ctrl.crc_check_tail  <= 1'b1;
         frame_ctrl.truncate_en     <= 1'b1;
         frame_ctrl.max_len         <= MAX_FRAME_RST;
         defer_rsvd_q               <= 2'h0;
      end else begin
         if (wr_frame) begin
            frame_ctrl.pad_cfg         <= wd[FC_PAD_LSB +: 3];
            frame_ctrl.crc_append      <= wd[FC_CRC_EN]; // RULE1
            frame_ctrl.crc_check_tail  <= !wd[FC_CRC_EN]; // RULE3
            frame_ctrl.crc_skip_header <= wd[FC_HEADER]; // RULE4
            frame_ctrl.truncate_en     <= !wd[FC_OVERSIZE]; // RULE5
            frame_ctrl.length_check    <= wd[FC_LEN_CHECK]; // RULE6
            frame_ctrl.full_duplex     <= wd[FC_FULL_DPX]; // RULE7
         end
         if (wr_defer) begin
            frame_ctrl.defer_unbounded <= wd[DC_DEFER]; // RULE8
            defer_rsvd_q <= wd[5:4] & DC_RSVD_MASK[5:4]; // RULE9
         end
         if (wr_len0)
            frame_ctrl.max_len[7:0] <= wd;
         if (wr_len1)
            frame_ctrl.max_len[15:8] <= avs_writedata[15:8];
      end
   end

   // management data buffers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         phy_reg_select_q      <= 5'h0;
         phy_write_data_low_q  <= 8'h0;
         phy_write_data_high_q <= 8'h0;
         cmd_scan_q            <= 1'b0;
         cmd_read_q            <= 1'b0;
      end else begin
         if (wr_sel)
            phy_reg_select_q <= wd[4:0]; // RULE15
         if (wr_wrl)
            phy_write_data_low_q <= wd; // RULE24
         if (wr_wrh)
            phy_write_data_high_q <= wd;
         if (wr_cmd) begin
            cmd_scan_q <= wd[CMD_SCAN];
            cmd_read_q <= wd[CMD_READ];
         end
      end
   end

   // management sequencer
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_q              <= ST_IDLE;
         dly_q                <= 2'h0;
         op_read_q            <= 1'b0;
         op_scan_q            <= 1'b0;
         eng_start_q          <= 1'b0;
         busy_q               <= 1'b0;
         scan_st_q            <= 1'b0;
         pend_q               <= 1'b0;
         phy_read_data_low_q  <= 8'h0;
         phy_read_data_high_q <= 8'h0;
      end else begin
         eng_start_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               // new operations are taken only in ST_IDLE; starts in other states are dropped
               if (start_any) begin
                  state_q   <= ST_DELAY;
                  dly_q     <= 2'(START_DELAY_CYC - 1);
                  op_read_q <= start_read || start_scan;
                  op_scan_q <= start_scan;
                  if (start_read || start_scan)
                     pend_q <= 1'b1; // RULE12
               end
            end
            ST_DELAY: begin
               if (dly_q == 2'h0) begin
                  state_q     <= ST_RUN;
                  busy_q      <= 1'b1; // RULE14
                  scan_st_q   <= op_scan_q; // RULE13
                  eng_start_q <= 1'b1;
               end else begin
                  dly_q <= dly_q - 2'h1;
               end
            end
            ST_RUN: begin
               if (eng_done) begin
                  if (op_read_q) begin
                     // phy words land here unchanged RULE16 RULE19 RULE20
                     phy_read_data_low_q  <= eng_rdata[7:0];
                     phy_read_data_high_q <= eng_rdata[15:8];
                     pend_q               <= 1'b0; // RULE12
                  end
                  if (op_scan_q && cmd_scan_q) begin
                     eng_start_q <= 1'b1; // RULE10
                  end else begin
                     state_q   <= ST_IDLE; // RULE11
                     busy_q    <= 1'b0; // RULE23
                     scan_st_q <= 1'b0;
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   mfc_mgmt_req_type eng_req;
   assign eng_req.is_read  = op_read_q;
   assign eng_req.reg_addr = phy_reg_select_q;
   assign eng_req.wdata    = {phy_write_data_high_q, phy_write_data_low_q};

   mfc_mgmt_engine #(
      .PHY_ADDR (PHY_ADDR),
      .BIT_CYC  (MGMT_BIT_CYC)
   ) u_engine (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .start    (eng_start_q),
      .req      (eng_req),
      .done     (eng_done),
      .rdata    (eng_rdata),
      .mdc      (mdc),
      .mdio_o   (mdio_o),
      .mdio_oe  (mdio_oe),
      .mdio_i   (mdio_i)
   );

   chk_busy_delay: assert property (@(posedge clk_sys) // RULE14
      disable iff (!rst_n)
      (idle && start_any) |=> !busy_q ##1 !busy_q ##1 busy_q)
      else $error("busy not set two cycles after start");

   chk_pend_set: assert property (@(posedge clk_sys) // RULE12
      disable iff (!rst_n)
      (idle && start_read) |=> pend_q [*2])
      else $error("pending not set on read start");

   chk_read_update: assert property (@(posedge clk_sys) // RULE12
      disable iff (!rst_n)
      (eng_done && op_read_q) |=> !pend_q &&
         {phy_read_data_high_q, phy_read_data_low_q} == $past(eng_rdata))
      else $error("read data not captured");

   chk_scan_repeat: assert property (@(posedge clk_sys) // RULE10
      disable iff (!rst_n)
      (eng_done && op_scan_q && cmd_scan_q) |=> eng_start_q && busy_q)
      else $error("poll did not restart");

   chk_scan_stop: assert property (@(posedge clk_sys) // RULE23
      disable iff (!rst_n)
      (state_q == ST_RUN && eng_done && !(op_scan_q && cmd_scan_q))
      |=> !busy_q && !scan_st_q && idle)
      else $error("busy or scan not cleared");

   chk_crc_mode: assert property (@(posedge clk_sys) // RULE3
      disable iff (!rst_n)
      frame_ctrl.crc_append != frame_ctrl.crc_check_tail)
      else $error("crc append and tail check both set");

   chk_bus_wait: assert property (@(posedge clk_sys) // RULE25
      disable iff (!rst_n)
      (req_any && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer timing wrong");

   chk_busy_bound: assert property (@(posedge clk_sys) // RULE21
      disable iff (!rst_n)
      (eng_start_q && !op_scan_q) |-> ##[255:258] !busy_q)
      else $error("single operation did not finish");

endmodule // mfc_mac_cfg_mgmt

// file: mfc_phy_model.sv
// mfc_phy_model: behavioural phy on the management pins
// assumes the bench resolves mdio with a pull-up when undriven
`timescale 1ns/1ps
module mfc_phy_model #(
   parameter logic [4:0] PHY_ADDR = 5'h01
) (
   // management pins
   input  wire logic        mdc,
   input  wire logic        mdio,
   output      logic        drv_en,
   output      logic        drv_val,
   // observation
   input  wire logic        link_up,
   output      logic [13:0] last_hdr,
   output      logic [15:0] frame_cnt
);
   import mfc_pkg::*;
   logic [15:0] regs [0:31];
   logic [31:0] sh;
   logic [5:0]  cnt;
   logic [15:0] rd_word;
   logic        link_latch;
   wire  [4:0]  ra   = {sh[3:0], mdio};
   wire         ours = last_hdr[9:5] == PHY_ADDR;
   // seven addresses exist; the two status words are read only
   function automatic logic writable(input logic [4:0] a);
      return a inside {5'h00, 5'h10, 5'h12, 5'h13, 5'h14};
   endfunction
   // start-up timer taken as run out at power-up
   initial begin
      cnt = '0;
      sh = '0;
      frame_cnt = '0;
      link_latch = 1'b1;
      drv_en = 1'b0;
      drv_val = 1'b1;
      last_hdr = '0;
      rd_word = '0;
      foreach (regs[j]) regs[j] = '0;
   end
   // a drop sticks until the status word is read
   always @(negedge link_up) link_latch <= 1'b0;
   always @(posedge mdc) begin
      sh <= {sh[30:0], mdio};
      if (cnt == 6'd0) begin
         if (mdio == 1'b0) cnt <= 6'd1;
      end else if (cnt == 6'd31) begin
         cnt <= 6'd0;
         frame_cnt <= frame_cnt + 16'h1;
         // unimplemented or read-only places keep their value
         if (last_hdr[11:10] == MF_OP_WRITE && ours
             && writable(last_hdr[4:0])) begin
            regs[last_hdr[4:0]] <= {sh[14:0], mdio};
         end
      end else begin
         cnt <= cnt + 6'd1;
      end
      if (cnt == 6'd13) begin
         last_hdr <= {sh[12:0], mdio};
         case (ra)
            5'h01: rd_word <= {13'h0, link_latch, 2'h0};
            5'h11: rd_word <= {5'h0, link_up, 10'h0};
            default: rd_word <= writable(ra) ? regs[ra] : ~frame_cnt;
         endcase
         if (ra == 5'h01) link_latch <= link_up;
      end
   end
   // turnaround zero, then data msb first, changed while mdc is low
   always @(negedge mdc) begin
      drv_en  <= last_hdr[11:10] == MF_OP_READ && ours && cnt >= 6'd15;
      drv_val <= (cnt == 6'd15) ? 1'b0 : rd_word[~cnt[3:0]];
   end
endmodule // mfc_phy_model

// file: mfc_mac_cfg_mgmt_bench.sv
// mfc_mac_cfg_mgmt_bench: self-checking bench of config and management
// assumes the behavioural phy model and a pull-up on the mdio wire
`timescale 1ns/1ps
module mfc_mac_cfg_mgmt_bench;
   import mfc_pkg::*;
   localparam logic [4:0] PHY_ADDR = 5'h01;
   logic               clk_sys, rst_n, avs_read, avs_write, avs_waitrequest;
   logic [3:0]         avs_address, avs_byteenable;
   logic [31:0]        avs_writedata, avs_readdata, rd, seed;
   mfc_frame_ctrl_type frame_ctrl;
   logic               mdc, mdio_o, mdio_oe, drv_en, drv_val, link_up;
   logic [13:0]        last_hdr;
   logic [15:0]        frame_cnt, w, f;
   logic [7:0]         v;
   logic [4:0]         pa [3];
   int                 miscompares, n_checks, cycles, i, k;
   // undriven mdio floats high
   wire mdio_w = mdio_oe ? mdio_o : (drv_en ? drv_val : 1'b1);

   mfc_mac_cfg_mgmt #(.PHY_ADDR(PHY_ADDR)) mfc_mac_cfg_mgmt_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .frame_ctrl(frame_ctrl), .mdc(mdc), .mdio_o(mdio_o),
      .mdio_oe(mdio_oe), .mdio_i(mdio_w));
   mfc_phy_model #(.PHY_ADDR(PHY_ADDR)) mfc_phy_model_inst (
      .mdc(mdc), .mdio(mdio_w), .drv_en(drv_en), .drv_val(drv_val),
      .link_up(link_up), .last_hdr(last_hdr), .frame_cnt(frame_cnt));

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   function automatic logic [31:0] cfg_exp(input logic [7:0] c);
      return {23'h0, c[7:5], c[4], ~c[4], c[3], ~c[2], c[1], c[0]};
   endfunction
   function automatic logic [31:0] cfg_seen();
      return {23'h0, frame_ctrl.pad_cfg, frame_ctrl.crc_append,
              frame_ctrl.crc_check_tail, frame_ctrl.crc_skip_header,
              frame_ctrl.truncate_en, frame_ctrl.length_check,
              frame_ctrl.full_duplex};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("checks=%0d miscompares=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // one access; held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= ~wr;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic wait_idle();
      int j;
      for (j = 0; j < 400; j++) begin
         bus(1'b0, REG_MGMT_STAT, '0, '0);
         if (rd[ST_BUSY] === 1'b0) break;
      end
   endtask
   // busy may lag the start, so look for it a few reads long
   task automatic run_op(input logic pend);
      int j;
      bus(1'b0, REG_MGMT_STAT, '0, '0);
      check({31'h0, rd[ST_PENDING]}, {31'h0, pend});
      for (j = 0; j < 4 && rd[ST_BUSY] !== 1'b1; j++)
         bus(1'b0, REG_MGMT_STAT, '0, '0);
      check({31'h0, rd[ST_BUSY]}, 32'h1);
      wait_idle();
      check(rd, 32'h0);
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 25000) begin
         miscompares++;
         summarize();
      end
   end

   initial begin
      rst_n = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = '0;
      avs_byteenable = '0;
      avs_writedata = '0;
      link_up = 1'b1;
      seed = 32'he5f0;
      miscompares = 0;
      n_checks = 0;
      cycles = 0;
      pa = '{5'h00, 5'h10, 5'h14};
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      check(cfg_seen(), cfg_exp(8'h00));
      for (i = 0; i < 16; i++) begin
         bus(1'b0, 4'(i), '0, '0);
         check(rd, (i == 9) ? {16'h0, MAX_FRAME_RST} : 32'h0);
      end
      for (i = 0; i < 10; i++) begin
         seed = xs(seed);
         v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : seed[7:0];
         if (v[FC_PAD_LSB]) v[FC_CRC_EN] = 1'b1;
         bus(1'b1, REG_FRAME_CFG, {24'h0, v}, 4'h1);
         bus(1'b0, REG_FRAME_CFG, '0, '0);
         check(rd, {24'h0, v});
         check(cfg_seen(), cfg_exp(v));
      end
      bus(1'b1, REG_MAX_LEN, {16'h0, seed[31:16]}, 4'h3);
      bus(1'b0, REG_MAX_LEN, '0, '0);
      check({16'h0, frame_ctrl.max_len}, {16'h0, seed[31:16]});
      check(rd, {16'h0, seed[31:16]});
      bus(1'b1, REG_DEFER_CTL, 32'h40, 4'h1);
      bus(1'b0, REG_DEFER_CTL, '0, '0);
      check(rd, 32'h40);
      check({31'h0, frame_ctrl.defer_unbounded}, 32'h1);
      bus(1'b1, REG_DEFER_CTL, 32'h0, 4'h1);
      bus(1'b0, REG_DEFER_CTL, '0, '0);
      check({31'h0, frame_ctrl.defer_unbounded}, 32'h0);
      // writes that must leave no trace
      bus(1'b1, REG_MGMT_STAT, 32'hff, 4'h1);
      bus(1'b1, REG_RD_LOW, 32'hff, 4'h1);
      bus(1'b1, REG_FRAME_CFG, 32'h5a, 4'h0);
      bus(1'b1, 4'hc, 32'hff, 4'h1);
      for (i = 0; i < 13; i++) begin
         bus(1'b0, 4'(i), '0, '0);
         if (i == 3 || i == 5 || i == 12) check(rd, 32'h0);
         if (i == 0) check(rd, {24'h0, v});
      end
      for (k = 0; k < 3; k++) begin
         seed = xs(seed);
         w = seed[15:0];
         if (k == 0) w = {7'h0, frame_ctrl.full_duplex, 8'h0};
         bus(1'b1, REG_PHY_SEL, {27'h0, pa[k]}, 4'h1);
         bus(1'b1, REG_WR_LOW, {24'h0, w[7:0]}, 4'h1);
         bus(1'b1, REG_WR_HIGH, {24'h0, w[15:8]}, 4'h1);
         run_op(1'b0);
         check({18'h0, last_hdr},
               {18'h0, MF_START, MF_OP_WRITE, PHY_ADDR, pa[k]});
         bus(1'b1, REG_MGMT_CMD, 32'h1, 4'h1);
         run_op(1'b1);
         f = frame_cnt;
         repeat (600) @(posedge clk_sys);
         check({16'h0, frame_cnt}, {16'h0, f});
         bus(1'b1, REG_MGMT_CMD, 32'h0, 4'h1);
         check({18'h0, last_hdr},
               {18'h0, MF_START, MF_OP_READ, PHY_ADDR, pa[k]});
         bus(1'b0, REG_RD_LOW, '0, '0);
         check(rd, {24'h0, w[7:0]});
         bus(1'b0, REG_RD_HIGH, '0, '0);
         check(rd, {24'h0, w[15:8]});
      end
      bus(1'b1, REG_PHY_SEL, 32'h11, 4'h1);
      bus(1'b1, REG_MGMT_CMD, 32'h2, 4'h1);
      for (i = 0; i < 400; i++) begin
         bus(1'b0, REG_MGMT_STAT, '0, '0);
         if (rd[ST_PENDING] === 1'b0 && rd[ST_BUSY] === 1'b1) break;
      end
      check(rd, 32'h3);
      bus(1'b0, REG_RD_HIGH, '0, '0);
      check(rd, 32'h04);
      link_up <= 1'b0;
      repeat (700) @(posedge clk_sys);
      bus(1'b0, REG_RD_HIGH, '0, '0);
      check(rd, 32'h00);
      bus(1'b1, REG_MGMT_CMD, 32'h0, 4'h1);
      wait_idle();
      check(rd, 32'h0);
      f = frame_cnt;
      repeat (600) @(posedge clk_sys);
      check({16'h0, frame_cnt}, {16'h0, f});
      summarize();
   end
endmodule // mfc_mac_cfg_mgmt_bench
